/* shared/isar_params.svh */
// offsets, codes and reset values of the input allocation router
`ifndef ISAR_PARAMS_SVH
`define ISAR_PARAMS_SVH

// register byte offsets on the wishbone slave
`define ISAR_OFS_CONTROL 8'h00
`define ISAR_OFS_BANK_A 8'h04
`define ISAR_OFS_BANK_B 8'h08
`define ISAR_OFS_BANK_C 8'h0c
`define ISAR_OFS_BANK_D 8'h10
`define ISAR_OFS_PIN_STATUS 8'h14
`define ISAR_OFS_FUNC_STATUS 8'h18

// reset values of the allocation banks and control register
`define ISAR_RST_CONTROL 16'h0000
`define ISAR_RST_BANK_A 16'h2100
`define ISAR_RST_BANK_B 16'h6543
`define ISAR_RST_BANK_C 16'h8888
`define ISAR_RST_BANK_D 16'h8888

// allocation mode value that enables free allocation
`define ISAR_MODE_FREE 4'h1

// allocation codes
`define ISAR_CODE_LAST_SLOT 4'h6
`define ISAR_CODE_ON 4'h7
`define ISAR_CODE_OFF 4'h8
`define ISAR_CODE_INV_BASE 4'h9

// number of input terminals
`define ISAR_SLOTS 7

`endif

/* shared/isar_pkg.sv */
// types shared by the input allocation router
`default_nettype none

package isar_pkg;

    // control method codes
    typedef enum logic [3:0] {
        ISAR_M_SPEED = 4'h0,
        ISAR_M_POS = 4'h1,
        ISAR_M_TORQUE = 4'h2,
        ISAR_M_ISPD = 4'h3,
        ISAR_M_ISPD_SPD = 4'h4,
        ISAR_M_ISPD_POS = 4'h5,
        ISAR_M_ISPD_TRQ = 4'h6,
        ISAR_M_POS_SPD = 4'h7,
        ISAR_M_POS_TRQ = 4'h8,
        ISAR_M_TRQ_SPD = 4'h9,
        ISAR_M_ZERO_CLAMP = 4'ha,
        ISAR_M_INHIBIT = 4'hb
    } isar_method_e;

    // one four-bit allocation code
    typedef logic [3:0] isar_code_t;

endpackage

`default_nettype wire

/* hdl/isar_router.sv */
// input allocation router: terminals to function signals, wishbone registers
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "isar_params.svh"

module isar_router (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [6:0] io_connector_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic servo_enable,
    output logic proportional_request,
    output logic forward_run_prohibit,
    output logic reverse_run_prohibit,
    output logic alarm_reset,
    output logic forward_torque_limit,
    output logic reverse_torque_limit,
    output logic direction_select,
    output logic speed_select_bit_a,
    output logic speed_select_bit_b,
    output logic control_method_switch,
    output logic zero_clamp,
    output logic reference_pulse_inhibit
);
    import isar_pkg::*;

    logic [15:0] control_q;
    logic [15:0] bank_a_q;
    logic [15:0] bank_b_q;
    logic [15:0] bank_c_q;
    logic [15:0] bank_d_q;
    logic [6:0] pin_meta_q;
    logic [6:0] pin_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [12:0] func_q;
    logic [12:0] func_d;
    logic [15:0] rd_d;
    logic free_mode;
    isar_method_e method;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // routed level for one code; slot codes 0-6 are active when the pin is low
    // unless the function defaults to active high (overtravel inputs); codes 9-F invert this
    function automatic logic isar_pick(input isar_code_t code,
                                       input logic [6:0] pins,
                                       input logic act_high,
                                       input logic no_force);
        logic lvl;
        lvl = 1'b0;
        if (code <= `ISAR_CODE_LAST_SLOT) begin
            lvl = pins[code[2:0]] ~^ act_high;
        end else if (code == `ISAR_CODE_ON) begin
            lvl = !no_force;
        end else if (code == `ISAR_CODE_OFF) begin
            lvl = 1'b0;
        end else begin
            lvl = pins[3'(code - `ISAR_CODE_INV_BASE)] ^ act_high;
        end
        return lvl;
    endfunction

    // merges written bytes into a 16-bit register
    function automatic logic [15:0] isar_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [15:0] v;
        v = old;
        if (sel[0]) begin
            v[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            v[15:8] = wd[15:8];
        end
        return v;
    endfunction

    assign free_mode = (bank_a_q[3:0] == `ISAR_MODE_FREE);
    assign method = isar_method_e'(control_q[3:0]);

    ////////////////////////////////////////////////////////////////////////
    // terminal synchroniser; first stage feeds only the second

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_meta_q <= 7'h7f;
            pin_q <= 7'h7f;
        end else begin
            pin_meta_q <= io_connector_in;
            pin_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // routing; bit order of func: servo, prop, fwd ot, rev ot, alarm,
    // fwd limit, rev limit, dir, speed_select_bit_a, speed_select_bit_b, method sw, zero clamp, inhibit

    always_comb begin
        func_d = 13'h0000;
        if (free_mode) begin
            // every field reads the same synchronised pins, so a shared
            // slot lands on all its functions in the same cycle
            func_d[0] = isar_pick(bank_a_q[7:4], pin_q, 1'b0, 1'b0);
            func_d[1] = isar_pick(bank_a_q[11:8], pin_q, 1'b0, 1'b0);
            func_d[2] = isar_pick(bank_a_q[15:12], pin_q, 1'b1, 1'b0);
            func_d[3] = isar_pick(bank_b_q[3:0], pin_q, 1'b1, 1'b0);
            func_d[4] = isar_pick(bank_b_q[7:4], pin_q, 1'b0, 1'b1);
            func_d[5] = isar_pick(bank_b_q[11:8], pin_q, 1'b0, 1'b0);
            func_d[6] = isar_pick(bank_b_q[15:12], pin_q, 1'b0, 1'b0);
            func_d[7] = isar_pick(bank_c_q[3:0], pin_q, 1'b0, 1'b0);
            func_d[8] = isar_pick(bank_c_q[7:4], pin_q, 1'b0, 1'b0);
            func_d[9] = isar_pick(bank_c_q[11:8], pin_q, 1'b0, 1'b0);
            func_d[10] = isar_pick(bank_c_q[15:12], pin_q, 1'b0, 1'b0);
            func_d[11] = isar_pick(bank_d_q[3:0], pin_q, 1'b0, 1'b0);
            func_d[12] = isar_pick(bank_d_q[7:4], pin_q, 1'b0, 1'b0);
        end else begin
            // fixed wiring; only the meaning of slots 1, 5, 6 moves
            func_d[0] = !pin_q[0];
            func_d[2] = pin_q[2];
            func_d[3] = pin_q[3];
            func_d[4] = !pin_q[4];
            case (method)
                ISAR_M_ISPD, ISAR_M_ISPD_SPD,
                ISAR_M_ISPD_POS, ISAR_M_ISPD_TRQ: begin
                    func_d[7] = !pin_q[1];
                    func_d[8] = !pin_q[5];
                    func_d[9] = !pin_q[6];
                end
                ISAR_M_POS_SPD, ISAR_M_POS_TRQ, ISAR_M_TRQ_SPD: begin
                    func_d[10] = !pin_q[1];
                    func_d[5] = !pin_q[5];
                    func_d[6] = !pin_q[6];
                end
                ISAR_M_ZERO_CLAMP: begin
                    func_d[11] = !pin_q[1];
                    func_d[5] = !pin_q[5];
                    func_d[6] = !pin_q[6];
                end
                ISAR_M_INHIBIT: begin
                    func_d[12] = !pin_q[1];
                    func_d[5] = !pin_q[5];
                    func_d[6] = !pin_q[6];
                end
                default: begin
                    // codes 0-2, and undefined C-F fall back to them
                    func_d[1] = !pin_q[1];
                    func_d[5] = !pin_q[5];
                    func_d[6] = !pin_q[6];
                end
            endcase
        end
    end

    // function outputs registered so no routing glitch reaches the drive
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            func_q <= 13'h0000;
        end else begin
            func_q <= func_d;
        end
    end

    assign servo_enable = func_q[0];
    assign proportional_request = func_q[1];
    assign forward_run_prohibit = func_q[2];
    assign reverse_run_prohibit = func_q[3];
    assign alarm_reset = func_q[4];
    assign forward_torque_limit = func_q[5];
    assign reverse_torque_limit = func_q[6];
    assign direction_select = func_q[7];
    assign speed_select_bit_a = func_q[8];
    assign speed_select_bit_b = func_q[9];
    assign control_method_switch = func_q[10];
    assign zero_clamp = func_q[11];
    assign reference_pulse_inhibit = func_q[12];

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after the strobe, write at the ack edge

    always_comb begin
        rd_d = 16'h0000;
        if (wb_adr_i == `ISAR_OFS_CONTROL) begin
            rd_d = control_q;
        end else if (wb_adr_i == `ISAR_OFS_BANK_A) begin
            rd_d = bank_a_q;
        end else if (wb_adr_i == `ISAR_OFS_BANK_B) begin
            rd_d = bank_b_q;
        end else if (wb_adr_i == `ISAR_OFS_BANK_C) begin
            rd_d = bank_c_q;
        end else if (wb_adr_i == `ISAR_OFS_BANK_D) begin
            rd_d = bank_d_q;
        end else if (wb_adr_i == `ISAR_OFS_PIN_STATUS) begin
            rd_d = {9'h000, pin_q};
        end else if (wb_adr_i == `ISAR_OFS_FUNC_STATUS) begin
            rd_d = {3'h0, func_q};
        end
    end

    // handshake and read data; unmapped addresses answer zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                dat_q <= {16'h0000, rd_d};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // register writes; status words are read only
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            control_q <= `ISAR_RST_CONTROL;
            bank_a_q <= `ISAR_RST_BANK_A;
            bank_b_q <= `ISAR_RST_BANK_B;
            bank_c_q <= `ISAR_RST_BANK_C;
            bank_d_q <= `ISAR_RST_BANK_D;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q) begin
            if (wb_adr_i == `ISAR_OFS_CONTROL) begin
                control_q <= isar_merge(control_q, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `ISAR_OFS_BANK_A) begin
                bank_a_q <= isar_merge(bank_a_q, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `ISAR_OFS_BANK_B) begin
                bank_b_q <= isar_merge(bank_b_q, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `ISAR_OFS_BANK_C) begin
                bank_c_q <= isar_merge(bank_c_q, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == `ISAR_OFS_BANK_D) begin
                bank_d_q <= isar_merge(bank_d_q, wb_dat_i, wb_sel_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_fixed_low0;
        (!free_mode && !io_connector_in[0]) [*3];
    endsequence

    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    chk_pin_sync_delay: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        s_fixed_low0 |=> servo_enable)
        else $error("servo enable not three cycles after pin");

    chk_fixed_core_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !free_mode |=> forward_run_prohibit == $past(pin_q[2])
            && alarm_reset == !$past(pin_q[4]))
        else $error("fixed core slots misrouted");

    chk_speed_bits_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!free_mode && control_q[3:0] >= 4'h3 && control_q[3:0] <= 4'h6)
        |=> speed_select_bit_b == !$past(pin_q[6]) && !proportional_request)
        else $error("speed select routing wrong");

    chk_torque_limit_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!free_mode && control_q[3:0] <= 4'h2)
        |=> forward_torque_limit == !$past(pin_q[5])
            && proportional_request == !$past(pin_q[1]))
        else $error("proportional or torque routing wrong");

    chk_method_switch_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!free_mode && control_q[3:0] >= 4'h7 && control_q[3:0] <= 4'h9)
        |=> control_method_switch == !$past(pin_q[1]) && !direction_select)
        else $error("method switch routing wrong");

    chk_zero_clamp_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!free_mode && control_q[3:0] == 4'ha)
        |=> zero_clamp == !$past(pin_q[1]))
        else $error("zero clamp routing wrong");

    chk_inhibit_map: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!free_mode && control_q[3:0] == 4'hb)
        |=> reference_pulse_inhibit == !$past(pin_q[1]))
        else $error("pulse inhibit routing wrong");

    chk_free_invert: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (free_mode && bank_a_q[15:12] == 4'hb)
        |=> forward_run_prohibit == !$past(pin_q[2]))
        else $error("inverted code polarity wrong");

    chk_force_codes: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (free_mode && bank_a_q[7:4] == 4'h7 && bank_b_q[11:8] == 4'h8)
        |=> servo_enable && !forward_torque_limit)
        else $error("forced code not honoured");

    chk_alarm_no_force: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (free_mode && bank_b_q[7:4] == 4'h7) |=> !alarm_reset)
        else $error("alarm reset forced on");

    chk_shared_slot: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (free_mode && bank_a_q[7:4] == bank_a_q[11:8]
            && bank_a_q[7:4] <= 4'h6)
        |=> servo_enable == proportional_request)
        else $error("shared slot split");

    chk_reset_codes: assert property (
        @(posedge ref_clk)
        !rst_b |=> bank_a_q == `ISAR_RST_BANK_A && bank_b_q == `ISAR_RST_BANK_B)
        else $error("default codes wrong after reset");

    chk_wb_ack_once: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> s_ack_pulse)
        else $error("ack not a single cycle");

endmodule

`default_nettype wire

/* test/isar_host_model.sv */
// host-side contact driver feeding the seven sequence input terminals
`timescale 1ns/1ps
`default_nettype none

module isar_host_model (
    input wire logic ref_clk,
    input wire logic [6:0] contact_req,
    input wire logic [3:0] settle_cycles,
    output logic [6:0] io_connector_in
);
    logic [6:0] held_q = 7'h7f;
    logic [3:0] wait_q = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // contacts idle open; a new request lands settle_cycles + 1 edges late,
    // like a slow relay, so the bench never leans on instant pins
    always @(posedge ref_clk) begin
        if (contact_req == held_q) begin
            wait_q <= 4'h0;
        end else if (wait_q >= settle_cycles) begin
            held_q <= contact_req;
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end

    assign io_connector_in = held_q;
endmodule

`default_nettype wire

/* test/isar_router_tb.sv */
// self-checking bench for the input allocation router
`timescale 1ns/1ps
`default_nettype none
`include "isar_params.svh"

module isar_router_tb;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc, wb_stb, wb_we, ack;
    logic [7:0] wb_adr;
    logic [31:0] wb_dat, dat_o, rdata;
    logic [3:0] wb_sel, settle;
    logic [6:0] req, pins;
    logic [12:0] fn;
    logic [63:0] dflt;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    always #10 ref_clk = ~ref_clk;

    isar_router u_isar_router (
        .ref_clk(ref_clk), .rst_b(rst_b), .io_connector_in(pins),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .servo_enable(fn[0]),
        .proportional_request(fn[1]), .forward_run_prohibit(fn[2]),
        .reverse_run_prohibit(fn[3]), .alarm_reset(fn[4]),
        .forward_torque_limit(fn[5]), .reverse_torque_limit(fn[6]),
        .direction_select(fn[7]), .speed_select_bit_a(fn[8]),
        .speed_select_bit_b(fn[9]), .control_method_switch(fn[10]),
        .zero_clamp(fn[11]), .reference_pulse_inhibit(fn[12])
    );

    isar_host_model u_isar_host_model (
        .ref_clk(ref_clk), .contact_req(req), .settle_cycles(settle),
        .io_connector_in(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // closing report, reached from the main sequence or the hang guard
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("BAD %0t run did not finish in time", $time);
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; read data taken at the ack edge only; a slave
    // that never answers is caught by the hang guard, not here
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
            input logic [15:0] wd, input logic [3:0] sel);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= {16'h0000, wd};
        wb_sel <= sel;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rdata = dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 16'h0000, 4'hf);
        check(rdata, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reference routing; banks packed {d, c, b, a}, servo at bit 0
    function automatic logic [12:0] exp_funcs(input logic [3:0] m,
            input logic [63:0] bk, input logic [6:0] p);
        logic [12:0] f;
        logic [3:0] c;
        logic hi;
        f = '0;
        if (bk[3:0] == `ISAR_MODE_FREE) begin
            for (int i = 0; i < 13; i++) begin
                c = bk[4 + 4 * i +: 4];
                hi = (i == 2) || (i == 3);
                if (c <= `ISAR_CODE_LAST_SLOT) begin
                    f[i] = hi ? p[c] : !p[c];
                end else if (c == `ISAR_CODE_ON) begin
                    f[i] = (i != 4);
                end else if (c >= `ISAR_CODE_INV_BASE) begin
                    f[i] = hi ? !p[c - `ISAR_CODE_INV_BASE] :
                        p[c - `ISAR_CODE_INV_BASE];
                end
            end
        end else begin
            f[0] = !p[0];
            f[2] = p[2];
            f[3] = p[3];
            f[4] = !p[4];
            if (m >= 4'h3 && m <= 4'h6) begin
                f[7] = !p[1];
                f[8] = !p[5];
                f[9] = !p[6];
            end else begin
                f[5] = !p[5];
                f[6] = !p[6];
                if (m >= 4'h7 && m <= 4'h9) f[10] = !p[1];
                else if (m == 4'ha) f[11] = !p[1];
                else if (m == 4'hb) f[12] = !p[1];
                else f[1] = !p[1];
            end
        end
        return f;
    endfunction

    // program method and banks, move contacts, compare ports and status
    task automatic apply(input logic [3:0] m, input logic [63:0] bk,
            input logic [6:0] p);
        wb_xfer(1'b1, `ISAR_OFS_CONTROL, {12'h000, m}, 4'h3);
        wb_xfer(1'b1, `ISAR_OFS_BANK_A, bk[15:0], 4'h3);
        wb_xfer(1'b1, `ISAR_OFS_BANK_B, bk[31:16], 4'h3);
        wb_xfer(1'b1, `ISAR_OFS_BANK_C, bk[47:32], 4'h3);
        wb_xfer(1'b1, `ISAR_OFS_BANK_D, bk[63:48], 4'h3);
        req <= p;
        repeat (12) @(posedge ref_clk);
        check({19'h0, fn}, {19'h0, exp_funcs(m, bk, p)});
        rd_chk(`ISAR_OFS_FUNC_STATUS, {19'h0, exp_funcs(m, bk, p)});
        rd_chk(`ISAR_OFS_PIN_STATUS, {25'h0, p});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_dat = 32'h0;
        wb_sel = 4'h0;
        req = 7'h7f;
        settle = 4'h0;
        dflt = {`ISAR_RST_BANK_D, `ISAR_RST_BANK_C, `ISAR_RST_BANK_B,
            `ISAR_RST_BANK_A};
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // reset values, unmapped and read-only places
        rd_chk(`ISAR_OFS_CONTROL, {16'h0, `ISAR_RST_CONTROL});
        rd_chk(`ISAR_OFS_BANK_A, {16'h0, `ISAR_RST_BANK_A});
        rd_chk(`ISAR_OFS_BANK_B, {16'h0, `ISAR_RST_BANK_B});
        rd_chk(`ISAR_OFS_BANK_C, {16'h0, `ISAR_RST_BANK_C});
        rd_chk(`ISAR_OFS_BANK_D, {16'h0, `ISAR_RST_BANK_D});
        wb_xfer(1'b1, 8'h1c, 16'hffff, 4'h3);
        rd_chk(8'h1c, 32'h0);
        wb_xfer(1'b1, `ISAR_OFS_FUNC_STATUS, 16'hffff, 4'h3);
        rd_chk(`ISAR_OFS_FUNC_STATUS,
            {19'h0, exp_funcs(4'h0, dflt, 7'h7f)});
        // terminal to output takes one model edge plus three router edges
        req <= 7'h7e;
        repeat (4) @(posedge ref_clk);
        check({31'h0, fn[0]}, 32'h0);
        @(posedge ref_clk);
        check({31'h0, fn[0]}, 32'h1);
        // low byte lane only
        wb_xfer(1'b1, `ISAR_OFS_BANK_C, 16'h1234, 4'h1);
        rd_chk(`ISAR_OFS_BANK_C,
            {16'h0, (`ISAR_RST_BANK_C & 16'hff00) | 16'h0034});
        settle <= 4'h3;
        // fixed routing for every method code, both contact patterns
        for (int m = 0; m < 16; m++) begin
            apply(m[3:0], dflt, 7'h55);
            apply(m[3:0], dflt, 7'h2a);
        end
        // fields ignored while the mode field is not the free value
        apply(4'h3, 64'h8888_8888_7777_7772, 7'h2a);
        // every code on every function, all fields set to one code
        for (int k = 0; k < 16; k++) begin
            apply(4'h0, {{15{k[3:0]}}, 4'h1}, 7'h55);
            apply(4'h0, {{15{k[3:0]}}, 4'h1}, 7'h2a);
        end
        // servo forced on and forward limit forced off in one setting
        apply(4'h0, 64'h8888_8888_6843_2171, 7'h55);
        // leave servo and overtravel at their safe polarity again
        apply(4'h0, dflt, 7'h7f);
        give_verdict();
    end
endmodule

`default_nettype wire
